// [core/acpt_pkg.sv]
// Purpose: Shared constants for the microprocessor-port tag and RM cell classifier.
// Assumes: Header word holds GFC/VPI, VCI, PTI and CLP in the usual ATM bit order.
// Notes:   Register offsets are byte addresses on a 32-bit AXI4-Lite bus.
//
// Overview of operation
// - Tag at VPI, VCI or either user field.
// - Output select zero: tag all cells to CPU.
// - Output select one: tag only specially routed cells.
// - User field two, 8-bit UTOPIA: omit tag silently.
// - CPU cells look up by tag or CPU port.
// - Input select picks all or PTI-matching cells.
// - User-field tag: skip HEC on PTI-matching cells.
// - Other cells follow the HEC mode bit.
// - Invalid tag port: discard, flag, count error.
// - User field two on 8-bit: discard, flag, count.
// - Every RM cell goes to RM/nrtVBR queue.
// - Mode 10, VC entry: PTI 110, PID 1 is VC RM.
// - Mode 10, VP entry: VP RM only at VCI 6.
// - Mode 0x: VCI 6 VP RM, else VC RM.
// - Merge available in mode 0x only.
// - Modes 01/10: VP RM routed by VCI 06h flag.
// - Mode 00: no VP RM special routing.
// - VC RM cells special-routed by connection flag in every mode.
// - Idle, multicast and per-port output address queues.
// - Special route: predefined by flag, user VC by PTI.

package acpt_pkg;

    // Register byte offsets.
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_ERR_FLAGS  = 8'h04;
    localparam logic [7:0]  REG_ERR_COUNT  = 8'h08;
    localparam logic [7:0]  REG_QSTAT      = 8'h0c;
    localparam logic [7:0]  REG_VP_VCI     = 8'h10;

    // Control register fields.
    localparam int          CTRL_TAGPOS    = 0;
    localparam int          CTRL_OUTSEL    = 3;
    localparam int          CTRL_INSEL     = 4;
    localparam int          CTRL_HECMODE   = 5;
    localparam int          CTRL_RMMODE    = 6;
    localparam int          CTRL_UTOPIA8   = 8;
    localparam int          CTRL_CPUPORT   = 9;
    localparam int          CTRL_TAGEN     = 14;
    localparam int          CTRL_PTIFLT    = 16;
    localparam logic [31:0] CTRL_MASK      = 32'h0007_7fff;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0020;
    localparam int          ERR_BADPORT    = 0;
    localparam logic [15:0] VP_VCI_RESET   = 16'h0020;

    // Tag positions.
    localparam logic [2:0]  POS_VPI_UNI    = 3'h0;
    localparam logic [2:0]  POS_VPI_NNI    = 3'h1;
    localparam logic [2:0]  POS_VCI        = 3'h2;
    localparam logic [2:0]  POS_USR1       = 3'h3;
    localparam logic [2:0]  POS_USR2       = 3'h4;

    // RM identification modes.
    localparam logic [1:0]  RM_MODE_00     = 2'h0;
    localparam logic [1:0]  RM_MODE_01     = 2'h1;

    // Cell constants.
    localparam logic [2:0]  PTI_RM         = 3'h6;
    localparam logic [15:0] VCI_VP_RM      = 16'h0006;
    localparam int          NUM_PORTS      = 30;
    localparam int          NUM_CELLS      = 16;
    localparam int          NUM_QUEUES     = 32;
    localparam logic [4:0]  Q_IDLE         = 5'h00;
    localparam logic [4:0]  Q_MCAST        = 5'h01;
    localparam logic [4:0]  Q_PORT0        = 5'h02;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage : acpt_pkg

// [core/acpt_cell_tag.sv]
// Purpose: Port tag insertion and extraction, RM cell classification and
//          cell address queues, configured over AXI4-Lite.
// Assumes: Cell strobes are one-cycle pulses synchronous to sys_clk.
// Notes:   Results appear one cycle after each strobe.
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns

module acpt_cell_tag
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // AXI4-Lite slave
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Ingress cell header and table results
    input  wire logic        inValid,
    input  wire logic [31:0] inHdr,
    input  wire logic [7:0]  inUsr1,
    input  wire logic [7:0]  inUsr2,
    input  wire logic [4:0]  inPort,
    input  wire logic        inPid,
    input  wire logic        inPredefined,
    input  wire logic        inSwitchMode,
    input  wire logic        inSpecConn,
    input  wire logic        inSpecVp,
    // Ingress classification results
    output logic             resValid,
    output logic [4:0]       resLookupPort,
    output logic [15:0]      resVpLookupVci,
    output logic             resUseVpEntry,
    output logic             resUseRmEntry,
    output logic             resRmVc,
    output logic             resRmVp,
    output logic             resClassRm,
    output logic             resSpecial,
    output logic             resMergeEn,
    output logic             resHecCheck,
    output logic             resDiscard,
    // Egress cells toward the microprocessor port
    input  wire logic        egValid,
    input  wire logic [31:0] egHdr,
    input  wire logic [7:0]  egUsr1,
    input  wire logic [7:0]  egUsr2,
    input  wire logic [4:0]  egSrcPort,
    input  wire logic        egSpecial,
    output logic             egOutValid,
    output logic [31:0]      egOutHdr,
    output logic [7:0]       egOutUsr1,
    output logic [7:0]       egOutUsr2,
    // Cell address queue commands
    input  wire logic        qCmdValid,
    input  wire logic        qCmdPop,
    input  wire logic [4:0]  qCmdQueue,
    input  wire logic [3:0]  qCmdAddr,
    output logic             qPopValid,
    output logic             qPopEmpty,
    output logic [3:0]       qPopAddr
);

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic                                    awPend;
        logic [7:0]                              awAddr;
        logic                                    wPend;
        logic [31:0]                             wData;
        logic [3:0]                              wStrb;
        logic                                    bValid;
        logic [1:0]                              bResp;
        logic                                    rValid;
        logic [31:0]                             rData;
        logic [1:0]                              rResp;
        logic [31:0]                             ctrl;
        logic [15:0]                             vpVci;
        logic                                    iipFlag;
        logic [15:0]                             errCount;
        logic                                    resValid;
        logic [4:0]                              resLookupPort;
        logic                                    resUseVpEntry;
        logic                                    resUseRmEntry;
        logic                                    resRmVc;
        logic                                    resRmVp;
        logic                                    resSpecial;
        logic                                    resMergeEn;
        logic                                    resHecCheck;
        logic                                    resDiscard;
        logic                                    egValid;
        logic [31:0]                             egHdr;
        logic [7:0]                              egUsr1;
        logic [7:0]                              egUsr2;
        logic [acpt_pkg::NUM_QUEUES-1:0][3:0]    qHead;
        logic [acpt_pkg::NUM_QUEUES-1:0][3:0]    qTail;
        logic [acpt_pkg::NUM_QUEUES-1:0][4:0]    qCount;
        logic [acpt_pkg::NUM_CELLS-1:0][3:0]     qNext;
        logic                                    qPopValid;
        logic                                    qPopEmpty;
        logic [3:0]                              qPopAddr;
    } acpt_state_t;

    // The idle queue starts holding every buffer address as one chain.
    function automatic acpt_state_t acpt_init();
        acpt_state_t s;
        s = '0;
        s.ctrl = acpt_pkg::CTRL_RESET;
        s.vpVci = acpt_pkg::VP_VCI_RESET;
        for (int i = 0; i < acpt_pkg::NUM_CELLS; i++)
        begin
            s.qNext[i] = 4'(i + 1);
        end
        s.qTail[acpt_pkg::Q_IDLE] = 4'(acpt_pkg::NUM_CELLS - 1);
        s.qCount[acpt_pkg::Q_IDLE] = 5'(acpt_pkg::NUM_CELLS);
        return s;
    endfunction : acpt_init

    localparam acpt_state_t RESET_STATE = acpt_init();

    acpt_state_t st;
    acpt_state_t next_st;

    // Five-bit tag taken from the selected header position.
    function automatic logic [4:0] acpt_get_tag(input logic [2:0]  pos,
                                                input logic [31:0] hdr,
                                                input logic [7:0]  u1,
                                                input logic [7:0]  u2);
        logic [4:0] t;
        unique case (pos)
            acpt_pkg::POS_VPI_UNI: t = hdr[27:23];
            acpt_pkg::POS_VPI_NNI: t = hdr[31:27];
            acpt_pkg::POS_VCI:     t = hdr[19:15];
            acpt_pkg::POS_USR1:    t = u1[4:0];
            default:               t = u2[4:0];
        endcase
        return t;
    endfunction : acpt_get_tag

    ////////////////////////////////////////////////////////////////////////////

    logic [2:0]  cfgTagPos;
    logic        cfgOutSel;
    logic        cfgInSel;
    logic        cfgHecMode;
    logic [1:0]  cfgRmMode;
    logic        cfgUtopia8;
    logic [4:0]  cfgCpuPort;
    logic        cfgTagEn;
    logic [2:0]  cfgPtiFlt;
    logic        udfTag;
    logic        usr2Narrow;
    logic        fromCpu;
    logic        ptiMatch;
    logic        tagExtract;
    logic [4:0]  inTag;
    logic        badTag;
    logic        rmShape;
    logic        vci6;
    logic        modeZeroX;
    logic        rmVc;
    logic        rmVp;
    logic        egAppend;
    logic [4:0]  egTag;
    logic [31:0] wrMerged;
    logic        doWrite;
    logic        iipSet;

    always_comb
    begin
        cfgTagPos  = st.ctrl[acpt_pkg::CTRL_TAGPOS +: 3];
        cfgOutSel  = st.ctrl[acpt_pkg::CTRL_OUTSEL];
        cfgInSel   = st.ctrl[acpt_pkg::CTRL_INSEL];
        cfgHecMode = st.ctrl[acpt_pkg::CTRL_HECMODE];
        cfgRmMode  = st.ctrl[acpt_pkg::CTRL_RMMODE +: 2];
        cfgUtopia8 = st.ctrl[acpt_pkg::CTRL_UTOPIA8];
        cfgCpuPort = st.ctrl[acpt_pkg::CTRL_CPUPORT +: 5];
        cfgTagEn   = st.ctrl[acpt_pkg::CTRL_TAGEN];
        cfgPtiFlt  = st.ctrl[acpt_pkg::CTRL_PTIFLT +: 3];
        udfTag     = (cfgTagPos == acpt_pkg::POS_USR1) || (cfgTagPos == acpt_pkg::POS_USR2);
        usr2Narrow = (cfgTagPos == acpt_pkg::POS_USR2) && cfgUtopia8;

        // Ingress path.
        fromCpu    = (inPort == cfgCpuPort);
        ptiMatch   = (inHdr[3:1] == cfgPtiFlt);
        tagExtract = fromCpu && cfgTagEn && (!cfgInSel || ptiMatch);
        inTag      = acpt_get_tag(cfgTagPos, inHdr, inUsr1, inUsr2);
        badTag     = tagExtract && (usr2Narrow
                     || (inTag >= 5'(acpt_pkg::NUM_PORTS)));
        rmShape    = (inHdr[3:1] == acpt_pkg::PTI_RM) && inPid;
        vci6       = (inHdr[19:4] == acpt_pkg::VCI_VP_RM);
        modeZeroX  = !cfgRmMode[1];
        if (modeZeroX)
        begin
            rmVp = rmShape && vci6;
            rmVc = rmShape && !vci6;
        end
        else
        begin
            rmVc = rmShape && !inSwitchMode;
            rmVp = rmShape && inSwitchMode && vci6;
        end

        // Egress path: tag only where the selected position exists.
        egAppend = cfgTagEn && (!cfgOutSel || egSpecial) && !usr2Narrow;
        egTag    = egSrcPort;

        // Register writes with byte lanes.
        for (int b = 0; b < 4; b++)
        begin
            wrMerged[b*8 +: 8] = st.wStrb[b] ? st.wData[b*8 +: 8] : 8'h00;
        end
        doWrite = st.awPend && st.wPend && !st.bValid;
        iipSet  = inValid && badTag;

        next_st = st;
        next_st.resValid  = inValid;
        next_st.egValid   = egValid;
        next_st.qPopValid = 1'b0;
        next_st.qPopEmpty = 1'b0;

        // AXI4-Lite write channel.
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_st.awPend = 1'b1;
            next_st.awAddr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_st.wPend = 1'b1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end
        if (st.bValid && s_axi_bready)
        begin
            next_st.bValid = 1'b0;
        end
        if (doWrite)
        begin
            next_st.awPend = 1'b0;
            next_st.wPend  = 1'b0;
            next_st.bValid = 1'b1;
            next_st.bResp  = acpt_pkg::RESP_OKAY;
            unique case (st.awAddr)
                acpt_pkg::REG_CTRL:
                begin
                    for (int b = 0; b < 4; b++)
                    begin
                        if (st.wStrb[b])
                        begin
                            next_st.ctrl[b*8 +: 8] = st.wData[b*8 +: 8]
                                                     & acpt_pkg::CTRL_MASK[b*8 +: 8];
                        end
                    end
                end
                acpt_pkg::REG_ERR_FLAGS:
                begin
                    if (wrMerged[acpt_pkg::ERR_BADPORT])
                    begin
                        next_st.iipFlag = 1'b0;
                    end
                end
                acpt_pkg::REG_VP_VCI:
                begin
                    if (st.wStrb[0])
                    begin
                        next_st.vpVci[7:0] = st.wData[7:0];
                    end
                    if (st.wStrb[1])
                    begin
                        next_st.vpVci[15:8] = st.wData[15:8];
                    end
                end
                acpt_pkg::REG_ERR_COUNT, acpt_pkg::REG_QSTAT: ;
                default: next_st.bResp = acpt_pkg::RESP_SLVERR;
            endcase
        end

        // AXI4-Lite read channel.
        if (st.rValid && s_axi_rready)
        begin
            next_st.rValid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_st.rValid = 1'b1;
            next_st.rResp  = acpt_pkg::RESP_OKAY;
            unique case (s_axi_araddr[7:0])
                acpt_pkg::REG_CTRL:      next_st.rData = st.ctrl;
                acpt_pkg::REG_ERR_FLAGS: next_st.rData = {31'h0, st.iipFlag};
                acpt_pkg::REG_ERR_COUNT: next_st.rData = {16'h0, st.errCount};
                acpt_pkg::REG_QSTAT:     next_st.rData = {11'h0, st.qCount[acpt_pkg::Q_MCAST],
                                                         11'h0, st.qCount[acpt_pkg::Q_IDLE]};
                acpt_pkg::REG_VP_VCI:    next_st.rData = {16'h0, st.vpVci};
                default:
                begin
                    next_st.rData = 32'h0;
                    next_st.rResp = acpt_pkg::RESP_SLVERR;
                end
            endcase
        end

        // A new error outranks a software clear in the same cycle.
        if (iipSet)
        begin
            next_st.iipFlag = 1'b1;
            if (st.errCount != 16'hffff)
            begin
                next_st.errCount = st.errCount + 16'h0001;
            end
        end

        // Ingress classification, one cycle after the strobe.
        if (inValid)
        begin
            next_st.resLookupPort = tagExtract ? inTag : cfgCpuPort;
            next_st.resDiscard    = badTag;
            next_st.resRmVc       = rmVc;
            next_st.resRmVp       = rmVp;
            // Mode 00 reads the VP entry only; mode 01 never needs it.
            next_st.resUseVpEntry = (cfgRmMode != acpt_pkg::RM_MODE_01);
            next_st.resUseRmEntry = rmVp && (cfgRmMode != acpt_pkg::RM_MODE_00);
            next_st.resMergeEn    = modeZeroX && (rmVc || rmVp);
            next_st.resHecCheck   = cfgHecMode
                                    && !(fromCpu && udfTag && ptiMatch);
            // Cells that arrive from the CPU port are never routed back to it.
            if (fromCpu)
            begin
                next_st.resSpecial = 1'b0;
            end
            else if (rmVc)
            begin
                next_st.resSpecial = inSpecConn;
            end
            else if (rmVp)
            begin
                next_st.resSpecial = (cfgRmMode != acpt_pkg::RM_MODE_00)
                                     && inSpecVp;
            end
            else if (inPredefined)
            begin
                next_st.resSpecial = inSpecConn;
            end
            else
            begin
                next_st.resSpecial = !inSwitchMode && ptiMatch;
            end
        end

        // Egress tag insertion.
        if (egValid)
        begin
            next_st.egHdr  = egHdr;
            next_st.egUsr1 = egUsr1;
            next_st.egUsr2 = egUsr2;
            if (egAppend)
            begin
                unique case (cfgTagPos)
                    acpt_pkg::POS_VPI_UNI: next_st.egHdr[27:23] = egTag;
                    acpt_pkg::POS_VPI_NNI: next_st.egHdr[31:27] = egTag;
                    acpt_pkg::POS_VCI:     next_st.egHdr[19:15] = egTag;
                    acpt_pkg::POS_USR1:    next_st.egUsr1[4:0]  = egTag;
                    default:               next_st.egUsr2[4:0]  = egTag;
                endcase
            end
        end

        // Linked address queues share one next-pointer array; one command a cycle.
        if (qCmdValid && qCmdPop)
        begin
            next_st.qPopValid = 1'b1;
            next_st.qPopAddr  = st.qHead[qCmdQueue];
            if (st.qCount[qCmdQueue] == 5'h00)
            begin
                next_st.qPopEmpty = 1'b1;
            end
            else
            begin
                next_st.qHead[qCmdQueue]  = st.qNext[st.qHead[qCmdQueue]];
                next_st.qCount[qCmdQueue] = st.qCount[qCmdQueue] - 5'h01;
            end
        end
        else if (qCmdValid && (st.qCount[qCmdQueue] != 5'(acpt_pkg::NUM_CELLS)))
        begin
            if (st.qCount[qCmdQueue] == 5'h00)
            begin
                next_st.qHead[qCmdQueue] = qCmdAddr;
            end
            else
            begin
                next_st.qNext[st.qTail[qCmdQueue]] = qCmdAddr;
            end
            next_st.qTail[qCmdQueue]  = qCmdAddr;
            next_st.qCount[qCmdQueue] = st.qCount[qCmdQueue] + 5'h01;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st <= RESET_STATE;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign s_axi_awready  = !st.awPend && !st.bValid;
    assign s_axi_wready   = !st.wPend && !st.bValid;
    assign s_axi_bvalid   = st.bValid;
    assign s_axi_bresp    = st.bResp;
    assign s_axi_arready  = !st.rValid;
    assign s_axi_rvalid   = st.rValid;
    assign s_axi_rdata    = st.rData;
    assign s_axi_rresp    = st.rResp;
    assign resValid       = st.resValid;
    assign resLookupPort  = st.resLookupPort;
    assign resVpLookupVci = st.vpVci;
    assign resUseVpEntry  = st.resUseVpEntry;
    assign resUseRmEntry  = st.resUseRmEntry;
    assign resRmVc        = st.resRmVc;
    assign resRmVp        = st.resRmVp;
    assign resClassRm     = st.resRmVc || st.resRmVp;
    assign resSpecial     = st.resSpecial;
    assign resMergeEn     = st.resMergeEn;
    assign resHecCheck    = st.resHecCheck;
    assign resDiscard     = st.resDiscard;
    assign egOutValid     = st.egValid;
    assign egOutHdr       = st.egHdr;
    assign egOutUsr1      = st.egUsr1;
    assign egOutUsr2      = st.egUsr2;
    assign qPopValid      = st.qPopValid;
    assign qPopEmpty      = st.qPopEmpty;
    assign qPopAddr       = st.qPopAddr;

endmodule : acpt_cell_tag

// [testbench/acpt_chk_sva.sv]
// Purpose: Result timing and RM class checks.
// Assumes: Sees only acpt_cell_tag ports.
// Notes:   Bound below the module.
`timescale 1ns/1ns
module acpt_chk_sva
(
    // Watched ports
    input logic        sys_clk, sys_rst, inValid, inPid, resValid, resRmVc, resRmVp,
    input logic        resClassRm, resMergeEn, egValid, egOutValid, inSwitchMode,
    input logic [31:0] inHdr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_res_follows: assert property (inValid |=> resValid)
        else $error("no result after cell");
    a_res_cause: assert property (resValid |-> $past(inValid))
        else $error("result without cell");
    a_eg_follows: assert property (egValid |=> egOutValid)
        else $error("no egress cell");
    a_rm_queue: assert property (resValid && $past(inHdr[3:1]) == 3'h6 && $past(inPid)
        && $past(inHdr[19:4]) != 16'h0006 && !$past(inSwitchMode) |-> resClassRm)
        else $error("vc rm cell not queued as rm");
    a_rm_kind: assert property (resValid |-> !(resRmVc && resRmVp))
        else $error("rm kind clash");
    a_vp_vci: assert property (resValid && resRmVp |-> $past(inHdr[19:4]) == 16'h0006)
        else $error("vp rm not at vci 6");
    a_rm_cell: assert property (resValid && resClassRm |-> $past(inHdr[3:1]) == 3'h6 && $past(inPid))
        else $error("rm without pti or pid");
    a_merge_rm: assert property (resMergeEn |-> resClassRm)
        else $error("merge on user cell");
endmodule : acpt_chk_sva
bind acpt_cell_tag acpt_chk_sva chk (.*);

// [testbench/acpt_cpu_model.sv]
// Purpose: Microprocessor side taking cells from its port.
// Assumes: One cell per egOutValid pulse.
// Notes:   Only counts; headers are judged by the bench.
`timescale 1ns/1ns
module acpt_cpu_model
(
    // Cells in
    input  logic sys_clk,
    input  logic egOutValid,
    output int   rxCount
);
    initial rxCount = 0;
    always @(posedge sys_clk)
        if (egOutValid)
            rxCount <= rxCount + 1;
endmodule : acpt_cpu_model

// [testbench/acpt_cell_tag_tb.sv]
// Purpose: Random and corner tests of tags, RM classes and queues.
// Assumes: cpu port 3 and tag enable in every control word.
// Notes:   Seed 75.
`timescale 1ns/1ns
module acpt_cell_tag_tb;
    logic sys_clk = 0, sys_rst = 1, inValid = 0, inPid = 1, inPredefined = 0, inSwitchMode = 0;
    logic inSpecConn = 0, inSpecVp = 0, egValid = 0, egSpecial = 0, qCmdValid = 0, qCmdPop = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, resValid, resUseVpEntry, resUseRmEntry, resRmVc, resRmVp, resClassRm;
    logic resSpecial, resMergeEn, resHecCheck, resDiscard, egOutValid, qPopValid, qPopEmpty;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, inHdr = 0, egHdr = 0;
    logic [31:0] s_axi_rdata, egOutHdr;
    logic [7:0]  inUsr1 = 0, inUsr2 = 0, egUsr1 = 0, egUsr2 = 0, egOutUsr1, egOutUsr2;
    logic [4:0]  inPort = 0, egSrcPort = 0, qCmdQueue = 0, resLookupPort;
    logic [3:0]  s_axi_wstrb = 4'hf, qCmdAddr = 0, qPopAddr;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] resVpLookupVci;
    logic [33:0] rd;
    logic [47:0] e;
    logic        vp, vc;
    int          errors = 0, total_checks = 0, rxCount, m, t, p;
    acpt_cell_tag uut (.*);
    acpt_cpu_model cpu (.*);
    initial forever #10 sys_clk = ~sys_clk;
    task automatic chk(input string n, input logic [47:0] s, input logic [47:0] x);
        total_checks++;
        if (s !== x)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    // Pulses last one cycle; results are read once that edge's updates have landed.
    task automatic go;
        @(posedge sys_clk);
        {inValid, egValid, qCmdValid} <= 3'h0;
        #1;
    endtask : go
    task automatic wr(input logic [31:0] d);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {32'h0, d, 3'h7};
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask : wr
    task automatic rg(input logic [31:0] a);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do
        begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end
        while (!s_axi_rvalid);
        rd = {s_axi_rresp, s_axi_rdata};
    endtask : rg
    initial
    begin
        void'($urandom(75));
        repeat (20) @(posedge sys_clk);
        sys_rst <= 0;
        @(posedge sys_clk);
        rg(32'h0);
        chk("ctrl", rd, 34'h20);
        chk("vp vci", resVpLookupVci, 16'h20);
        rg(32'h40);
        chk("unmapped", rd, 34'h200000000);
        {qCmdValid, qCmdPop, qCmdQueue} <= 7'h60;
        go;
        chk("idle head", {qPopValid, qPopEmpty, qPopAddr}, 6'h20);
        t = $urandom % 16;
        {qCmdValid, qCmdPop, qCmdQueue, qCmdAddr} <= {7'h42, 4'(t)};
        go;
        {qCmdValid, qCmdPop} <= 2'h3;
        go;
        chk("out queue", {qPopValid, qPopEmpty, qPopAddr}, 6'h20 | t);
        $display("queue test done");
        for (int i = 0; i < 12; i++)
        begin
            m = i / 4;
            wr(32'h4620 | m << 6); // no ABR VCs nested in a VP under mode 0x
            {inSwitchMode, inSpecConn, inSpecVp} <= {i[1], 2'($urandom)};
            inHdr <= {12'h0, i[0] ? 16'h6 : 16'(7 + $urandom % 900), 4'hc};
            {inPort, inValid} <= 6'h3;
            go;
            vp = i[0] && (m < 2 || inSwitchMode);
            vc = m < 2 ? !i[0] : !inSwitchMode;
            chk("rm", {resRmVp, resRmVc, resClassRm}, {vp, vc, vp | vc});
            chk("merge", resMergeEn, m < 2);
            chk("special", resSpecial, vp ? m > 0 && inSpecVp : vc && inSpecConn);
            chk("entries", {resUseVpEntry, resUseRmEntry}, {m != 1, vp && m > 0});
        end
        $display("rm test done");
        wr(32'h4622);
        for (int k = 0; k < 6; k++)
        begin
            t = k == 5 ? 31 : $urandom % 30;
            {inHdr, inPort, inValid} <= {12'h0, 5'(t), 15'h0, 6'h7};
            go;
            if (k < 5) chk("lookup", resLookupPort, t);
            chk("discard", resDiscard, k == 5);
        end
        rg(32'h4);
        chk("port flag", rd[0], 1);
        wr(32'h4724);
        inValid <= 1;
        go;
        chk("usr2 discard", resDiscard, 1);
        chk("hec skip", resHecCheck, 0);
        rg(32'h8);
        chk("error count", rd, 34'h2);
        $display("tag test done");
        for (int i = 0; i < 10; i++)
        begin
            p = i / 2;
            wr(32'h4620 | p | (i % 2) << 3 | ($urandom % 2) << 8);
            e = {$urandom, 16'($urandom)};
            {egHdr, egUsr1, egUsr2, egSrcPort, egSpecial, egValid} <= {e, 5'($urandom % 30), 2'($urandom | 1)};
            go;
            if ((i % 2 == 0 || egSpecial) && !(p == 4 && s_axi_wdata[8]))
                e[(p == 0 ? 39 : p == 1 ? 43 : p == 2 ? 31 : p == 3 ? 8 : 0) +: 5] = egSrcPort;
            chk("egress", {egOutHdr, egOutUsr1, egOutUsr2}, e);
        end
        $display("egress test done");
        go;
        chk("cpu cells", rxCount, 10);
        wrap_up;
    end
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        wrap_up;
    end
endmodule : acpt_cell_tag_tb
